// file: hdl/hap_defines.svh
// Constants of the hash automatic padding block
// Notes on behaviour
// RULE1 - Padding uses stored total message byte length
// RULE2 - Byte length converted to bits, closes final block
// RULE3 - Each input write subtracts its byte count; the code subtracts no more than the bytes remaining
// RULE4 - Padding starts when remaining counter hits zero
// RULE5 - Whole message: counter loaded equal to length
// RULE6 - Resumed message: counter holds only remaining bytes
// RULE7 - Both values zero disables padding entirely
// RULE8 - One bit, zeros, length; one or two blocks
`ifndef HAP_DEFINES_SVH
`define HAP_DEFINES_SVH
`define HAP_WORD_W     32
`define HAP_BLK_WORDS  16
`define HAP_IDX_W      4
`define HAP_LEN_IDX    4'hE
`define HAP_PAD_WORD   32'h80000000
`define HAP_PAD_BYTE   8'h80
`define HAP_BIT_SHIFT  3
`define HAP_BUF_DEPTH  2
`define HAP_LEN_W      32
`endif

// file: hdl/hap_pkg.sv
// Types of the hash automatic padding block
package hap_pkg;
  // Word source state
  typedef enum logic [2:0] {
    HAP_PASS   = 3'h0,
    HAP_ONE    = 3'h1,
    HAP_ZERO   = 3'h2,
    HAP_LEN_HI = 3'h3,
    HAP_LEN_LO = 3'h4
  } hap_state_t;
endpackage

// file: hdl/hap_if.sv
// Word stream carrier between padding logic and its buffer
`timescale 1ns/10ps
interface hap_if #(
  parameter int W = 32
);
  logic         valid;  // Word offered
  logic         ready;  // Word taken
  logic [W-1:0] data;   // Word
  logic         last;   // Final word of the message
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface

// file: hdl/hap_buf.sv
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/10ps
`include "hap_defines.svh"
module hap_buf #(
  parameter int W     = `HAP_WORD_W,
  parameter int DEPTH = `HAP_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  // Streams
  hap_if.snk        s_in,
  hap_if.src        s_out
);
  // Pointers are one bit wide, so only two entries can be served
  if (DEPTH != 2) begin
    $error("hap_buf: DEPTH must be 2");
  end

  // Whole buffer state
  typedef struct packed {
    logic [1:0][W:0] mem;   // Entries, last flag on top
    logic            wr;    // Write pointer
    logic            rd;    // Read pointer
    logic [1:0]      cnt;   // Entries held
  } hap_buf_st_t;

  hap_buf_st_t st_r;   // Registered state
  hap_buf_st_t st_nxt; // Next state
  logic        push;   // Word enters
  logic        pop;    // Word leaves

  // Honest full and empty drive the handshakes
  assign s_in.ready  = (st_r.cnt != 2'h2);
  assign s_out.valid = (st_r.cnt != 2'h0);
  assign s_out.data  = st_r.mem[st_r.rd][W-1:0];
  assign s_out.last  = st_r.mem[st_r.rd][W];
  assign push        = s_in.valid && s_in.ready;
  assign pop         = s_out.valid && s_out.ready;

  // Next state
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr] = {s_in.last, s_in.data};
      st_nxt.wr           = ~st_r.wr;
    end
    if (pop) begin
      st_nxt.rd = ~st_r.rd;
    end
    // Simultaneous push and pop keeps the count
    case ({push, pop})
      2'b10:   st_nxt.cnt = st_r.cnt + 2'h1;
      2'b01:   st_nxt.cnt = st_r.cnt - 2'h1;
      default: st_nxt.cnt = st_r.cnt;
    endcase
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end
endmodule

// file: hdl/hap_top.sv
// Hash automatic padding: byte counting, pad and length insertion
`timescale 1ns/10ps
`include "hap_defines.svh"
module hap_top #(
  parameter int LEN_W = `HAP_LEN_W
) (
  // Clock, reset, enable
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_ce,
  // Configuration writes
  input  wire logic             i_len_wr,       // Store message_length_bytes
  input  wire logic             i_cnt_wr,       // Store remaining_byte_counter
  input  wire logic [LEN_W-1:0] i_cfg_value,    // Value for either write
  // Input data writes
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [31:0]      i_in_data,      // First byte in bits 31:24
  input  wire logic [1:0]       i_in_nbytes_m1, // Bytes in word minus one
  // Word stream to the hash core
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [31:0]           o_out_data,
  output logic                  o_out_last,
  // Status
  output logic [LEN_W-1:0]      o_remaining_byte_counter,
  output logic [LEN_W-1:0]      o_message_length_bytes,
  output logic                  o_pad_busy,
  output logic                  o_msg_done      // Pulse: final word buffered
);
  // Bit length must fit the 64-bit slot; the zero fill above it is never empty
  if (LEN_W < 8 || LEN_W > 60) begin
    $error("hap_top: LEN_W must be 8..60");
  end

  // Words enter the buffer in message order: data, then the marker, then
  // zero fill up to word 14 of the block, then the bit length as two words.
  // The word index restarts on any configuration write, so software must
  // program length and counter at a block boundary of the message.
  // Only the write that moves a nonzero counter to zero arms padding; a
  // counter already at zero lets later words pass without padding.
  // Lengths are kept in bytes; the bit form exists only on the way out.
  // Limitation: one message at a time; a new configuration mid-padding
  // changes the length word still to come.
  // Back-pressure from the hash core stalls the word source, never drops.

  // Whole block state
  typedef struct packed {
    hap_pkg::hap_state_t          state; // Word source
    logic [`HAP_IDX_W-1:0]        widx;  // Word index in block
    logic [LEN_W-1:0]             len;   // message_length_bytes
    logic [LEN_W-1:0]             cnt;   // remaining_byte_counter
    logic                         done;  // Message complete pulse
  } hap_st_t;

  hap_st_t               st_r;     // Registered state
  hap_st_t               st_nxt;   // Next state
  logic [63:0]           len_bits; // Length in bits
  logic [LEN_W-1:0]      nbytes;   // Bytes of this write
  logic [LEN_W-1:0]      dec;      // Amount actually subtracted
  logic                  pad_en;   // Padding armed
  logic                  take;     // Word accepted by buffer
  logic [`HAP_IDX_W-1:0] idx_inc;  // Index after this word
  logic                  fin;      // This write empties the counter
  logic [1:0]            fin_m1;   // Counted bytes of final write minus one

  // Carriers between word source and buffer
  hap_if #(.W(`HAP_WORD_W)) w_in ();
  hap_if #(.W(`HAP_WORD_W)) w_out ();

  // Two-entry buffer lets the hash core stall without losing a word
  hap_buf #(
    .W     (`HAP_WORD_W),
    .DEPTH (`HAP_BUF_DEPTH)
  ) u_buf (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_ce    (i_ce),
    .s_in    (w_in.snk),
    .s_out   (w_out.src)
  );

  // Hash core side comes straight from the buffer
  assign o_out_valid    = w_out.valid;
  assign o_out_data     = w_out.data;
  assign o_out_last     = w_out.last;
  assign w_out.ready    = i_out_ready;

  // Length slot holds the byte size times eight
  assign len_bits = {{(64 - LEN_W - `HAP_BIT_SHIFT){1'b0}}, st_r.len, 3'b000}; // RULE2
  assign nbytes   = LEN_W'(i_in_nbytes_m1) + LEN_W'(1);
  // Saturate so a final write offering more bytes than remain cannot wrap the counter
  assign dec      = (nbytes > st_r.cnt) ? st_r.cnt : nbytes; // RULE3
  // Both fields zero means no padding
  assign pad_en   = (st_r.len != '0) || (st_r.cnt != '0); // RULE7
  assign idx_inc  = st_r.widx + `HAP_IDX_W'(1);
  // Word accepted by the buffer this cycle
  assign take     = w_in.valid && w_in.ready;
  // Final write: padding armed and the counter empties with this word
  assign fin      = pad_en && (st_r.cnt != '0) && (dec == st_r.cnt); // RULE4
  // Marker follows the last counted byte, not the last byte offered
  assign fin_m1   = 2'(dec - LEN_W'(1));

  // Input is refused while padding words are emitted
  // Ready also waits on buffer room, so back-pressure reaches the writer
  assign o_in_ready = (st_r.state == hap_pkg::HAP_PASS) && w_in.ready;

  // Word source and next state
  always_comb begin
    // Hold by default; no word offered
    st_nxt     = st_r;
    st_nxt.done = 1'b0;
    w_in.valid = 1'b0;
    w_in.data  = '0;
    w_in.last  = 1'b0;
    case (st_r.state)
      hap_pkg::HAP_PASS: begin
        w_in.valid = i_in_valid;
        // Unused low bytes are cleared
        case (i_in_nbytes_m1)
          2'h0:    w_in.data = {i_in_data[31:24], 24'h0};
          2'h1:    w_in.data = {i_in_data[31:16], 16'h0};
          2'h2:    w_in.data = {i_in_data[31:8], 8'h0};
          default: w_in.data = i_in_data;
        endcase
        if (fin) begin
          // Final data write: marker byte follows the last counted byte
          // Bytes offered beyond the count are not message and are dropped
          case (fin_m1) // RULE8
            2'h0:    w_in.data = {i_in_data[31:24], `HAP_PAD_BYTE, 16'h0};
            2'h1:    w_in.data = {i_in_data[31:16], `HAP_PAD_BYTE, 8'h0};
            2'h2:    w_in.data = {i_in_data[31:8], `HAP_PAD_BYTE};
            default: w_in.data = i_in_data;
          endcase
        end
        // Counter and index move only on an accepted word
        if (take) begin
          st_nxt.widx = idx_inc;
          st_nxt.cnt  = st_r.cnt - dec; // RULE3
          // Counter reaching zero starts padding on its own
          if (fin) begin // RULE4
            // No room for the marker in a full final word
            if (fin_m1 == 2'h3) begin
              st_nxt.state = hap_pkg::HAP_ONE;
            end else if (idx_inc == `HAP_LEN_IDX) begin
              st_nxt.state = hap_pkg::HAP_LEN_HI;
            end else begin
              st_nxt.state = hap_pkg::HAP_ZERO;
            end
          end
        end
      end
      hap_pkg::HAP_ONE: begin
        // Full final word: marker takes a word of its own
        w_in.valid = 1'b1;
        w_in.data  = `HAP_PAD_WORD; // RULE8
        if (take) begin
          st_nxt.widx  = idx_inc;
          st_nxt.state = (idx_inc == `HAP_LEN_IDX) ? hap_pkg::HAP_LEN_HI : hap_pkg::HAP_ZERO;
        end
      end
      hap_pkg::HAP_ZERO: begin
        // Zero fill; wraps into a second block when no room was left
        // Data stays zero from the default above
        w_in.valid = 1'b1;
        if (take) begin
          st_nxt.widx = idx_inc;
          if (idx_inc == `HAP_LEN_IDX) begin // RULE8
            st_nxt.state = hap_pkg::HAP_LEN_HI;
          end
        end
      end
      hap_pkg::HAP_LEN_HI: begin
        // Upper half of the 64-bit bit length
        w_in.valid = 1'b1;
        w_in.data  = len_bits[63:32]; // RULE2
        if (take) begin
          st_nxt.widx  = idx_inc;
          st_nxt.state = hap_pkg::HAP_LEN_LO;
        end
      end
      hap_pkg::HAP_LEN_LO: begin
        // Lower half closes the message
        w_in.valid = 1'b1;
        w_in.data  = len_bits[31:0]; // RULE2
        w_in.last  = 1'b1;
        if (take) begin
          st_nxt.widx  = '0;
          st_nxt.done  = 1'b1; // RULE8
          st_nxt.state = hap_pkg::HAP_PASS;
        end
      end
      default: begin
        // Unused codes fall back to pass-through
        st_nxt.state = hap_pkg::HAP_PASS;
      end
    endcase
    // Configuration writes restart block alignment
    // A write beats a decrement of the same cycle
    if (i_len_wr) begin
      st_nxt.len  = i_cfg_value; // RULE1
      st_nxt.widx = '0;
    end
    if (i_cnt_wr) begin
      st_nxt.cnt  = i_cfg_value; // RULE5 RULE6
      st_nxt.widx = '0;
    end
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // Status straight from state flops
  assign o_remaining_byte_counter = st_r.cnt;
  assign o_message_length_bytes   = st_r.len;
  // Busy covers marker, fill and length words
  assign o_pad_busy               = (st_r.state != hap_pkg::HAP_PASS);
  assign o_msg_done               = st_r.done;
endmodule

// file: tb/hap_properties.sv
// Port checker for the hash automatic padding block
`timescale 1ns/10ps
module hap_properties #(
  parameter int LEN_W = 32
) (
  // Clock and reset
  input wire logic             i_clk,
  input wire logic             i_rst_b,
  // Watched inputs
  input wire logic             i_ce,
  input wire logic             i_len_wr,
  input wire logic             i_cnt_wr,
  input wire logic [LEN_W-1:0] i_cfg_value,
  input wire logic             i_in_valid,
  input wire logic [1:0]       i_in_nbytes_m1,
  input wire logic             i_out_ready,
  // Watched outputs
  input wire logic             o_in_ready,
  input wire logic             o_out_valid,
  input wire logic [31:0]      o_out_data,
  input wire logic             o_out_last,
  input wire logic [LEN_W-1:0] o_remaining_byte_counter,
  input wire logic [LEN_W-1:0] o_message_length_bytes,
  input wire logic             o_pad_busy,
  input wire logic             o_msg_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Data word taken with no config write competing for the counter
  wire             take = i_ce && i_in_valid && o_in_ready && !i_len_wr && !i_cnt_wr;
  wire [LEN_W-1:0] nb   = LEN_W'(i_in_nbytes_m1) + LEN_W'(1);  // Bytes in the word
  // Padding run ends: busy then idle
  sequence s_pad_end;
    o_pad_busy ##1 !o_pad_busy;
  endsequence
  chk_len_store: assert property (i_ce && i_len_wr |=> o_message_length_bytes == $past(i_cfg_value))
    else $error("length not stored");
  chk_cnt_dec: assert property (take && o_remaining_byte_counter > nb |=>
    o_remaining_byte_counter == $past(o_remaining_byte_counter) - $past(nb)) else $error("counter not reduced");
  chk_pad_start: assert property (take && o_remaining_byte_counter != 0 && o_remaining_byte_counter <= nb
    |=> o_pad_busy) else $error("padding not started");
  chk_pad_off: assert property (!o_pad_busy && o_message_length_bytes == 0 && o_remaining_byte_counter == 0
    && !i_len_wr && !i_cnt_wr |=> !o_pad_busy) else $error("padding while disabled");
  chk_busy_refuse: assert property (o_pad_busy |-> !o_in_ready) else $error("input taken while padding");
  chk_done_end: assert property (s_pad_end |-> o_msg_done) else $error("no done at padding end");
  chk_done_pulse: assert property (o_msg_done && i_ce |=> !o_msg_done) else $error("done longer than a cycle");
  chk_ce_freeze: assert property (!i_ce |=> $stable(o_remaining_byte_counter) && $stable(o_message_length_bytes)
    && $stable(o_pad_busy) && $stable(o_out_valid)) else $error("state moved with enable low");
  chk_out_hold: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
    else $error("stalled word changed");
  chk_len_word: assert property (o_out_valid && o_out_last |-> o_out_data == 32'(o_message_length_bytes << 3))
    else $error("wrong bit length word");
endmodule
bind hap_top hap_properties #(.LEN_W(LEN_W)) u_props (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_len_wr(i_len_wr), .i_cnt_wr(i_cnt_wr),
  .i_cfg_value(i_cfg_value), .i_in_valid(i_in_valid), .i_in_nbytes_m1(i_in_nbytes_m1),
  .i_out_ready(i_out_ready), .o_in_ready(o_in_ready), .o_out_valid(o_out_valid), .o_out_data(o_out_data),
  .o_out_last(o_out_last), .o_remaining_byte_counter(o_remaining_byte_counter),
  .o_message_length_bytes(o_message_length_bytes), .o_pad_busy(o_pad_busy), .o_msg_done(o_msg_done));

// file: tb/hap_top_test.sv
// Self-checking bench for the hash automatic padding block
`timescale 1ns/10ps
module hap_top_test;
  logic        i_clk, i_rst_b, i_ce, i_len_wr, i_cnt_wr, i_in_valid, i_out_ready;  // Stimulus
  logic [31:0] i_cfg_value, i_in_data;
  logic [1:0]  i_in_nbytes_m1;
  logic        o_in_ready, o_out_valid, o_out_last, o_pad_busy, o_msg_done;       // Observed
  logic [31:0] o_out_data, o_remaining_byte_counter, o_message_length_bytes;
  int          n_fail = 0, checked = 0, cyc = 0;
  bit          slow = 0, hold = 0;  // Receiver stall controls
  logic [32:0] got[$];              // Words seen, last flag on top
  // Rows: length, counter, bytes sent, slow receiver
  int rows[13][4] = '{'{1,1,1,0}, '{2,2,2,1}, '{3,3,3,0}, '{4,4,4,1}, '{7,7,7,0}, '{55,55,55,1},
                      '{56,56,56,0}, '{64,64,64,1}, '{100,4,4,0}, '{1,1,4,0}, '{59,59,59,0},
                      '{52,52,52,1}, '{0,0,8,1}};
  hap_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_len_wr(i_len_wr), .i_cnt_wr(i_cnt_wr),
    .i_cfg_value(i_cfg_value), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .i_in_data(i_in_data),
    .i_in_nbytes_m1(i_in_nbytes_m1), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
    .o_out_data(o_out_data), .o_out_last(o_out_last), .o_remaining_byte_counter(o_remaining_byte_counter),
    .o_message_length_bytes(o_message_length_bytes), .o_pad_busy(o_pad_busy), .o_msg_done(o_msg_done));
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  // Receiver stalls on request, so buffer back-pressure is exercised
  always @(negedge i_clk) i_out_ready <= !hold && !(slow && cyc[1]);
  // Collects taken words; the timeout cuts a hang short
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_out_valid && i_out_ready) got.push_back({o_out_last, o_out_data});
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One message: configure, send bytes, then compare the whole stream
  task automatic run(input int len, cnt, nb, sl);
    logic [7:0]  b[$];
    logic [63:0] bits;
    int          i, k, w, rem;
    bit          pad;
    slow = sl;
    got.delete();
    rem = cnt;
    pad = (cnt != 0);
    @(negedge i_clk) {i_len_wr, i_cfg_value} = {1'b1, 32'(len)};
    @(negedge i_clk) {i_len_wr, i_cnt_wr, i_cfg_value} = {2'b01, 32'(cnt)};
    @(negedge i_clk) i_cnt_wr = 0;
    chk(o_message_length_bytes, len, "length");
    for (i = 0; i < nb; i += 4) begin
      k = (nb - i < 4) ? nb - i : 4;
      i_in_valid = 1;
      i_in_nbytes_m1 = 2'(k - 1);
      i_in_data = {8'(i + 1), 8'(i + 2), 8'(i + 3), 8'(i + 4)};
      while (!o_in_ready) @(negedge i_clk);
      @(negedge i_clk);
      // Bytes beyond the counter are not message once padding is armed
      for (w = 0; w < k; w++) if (!pad || w < rem) b.push_back(8'(i + w + 1));
      rem = (rem > k) ? rem - k : 0;
      chk(o_remaining_byte_counter, rem, "counter");
    end
    i_in_valid = 0;
    for (w = 0; w < 300 && pad && !o_msg_done; w++) @(negedge i_clk);
    chk(o_msg_done, pad, "done");
    repeat (10) @(negedge i_clk);
    if (pad) begin
      b.push_back(8'h80);
      while (b.size() % 64 != 56) b.push_back(8'h00);
      bits = 64'(len) << 3;
      for (w = 7; w >= 0; w--) b.push_back(bits[8*w +: 8]);
    end
    chk(got.size(), b.size() / 4, "word count");
    for (i = 0; i < got.size() && i < b.size() / 4; i++)
      chk(got[i], {pad && (4*i + 4 == b.size()), b[4*i], b[4*i+1], b[4*i+2], b[4*i+3]}, "word");
  endtask
  initial begin
    {i_rst_b, i_ce, i_len_wr, i_cnt_wr, i_in_valid} = 5'b01000;
    {i_cfg_value, i_in_data, i_in_nbytes_m1} = '0;
    repeat (5) @(negedge i_clk);
    chk({o_in_ready, o_out_valid, o_pad_busy, o_msg_done}, 4'b1000, "reset state");
    i_rst_b = 1;
    foreach (rows[r]) begin
      run(rows[r][0], rows[r][1], rows[r][2], rows[r][3]);
      $display("test %0d done", r);
    end
    // Receiver stopped: two words fit, the third is refused until room frees
    hold = 1;
    got.delete();
    @(negedge i_clk) i_in_valid = 1;
    repeat (3) @(negedge i_clk);
    chk(o_in_ready, 0, "full buffer");
    hold = 0;
    while (!o_in_ready) @(negedge i_clk);
    @(negedge i_clk) i_in_valid = 0;
    repeat (6) @(negedge i_clk);
    chk(got.size(), 3, "stall word count");
    $display("test stall done");
    // Clock enable low: configuration strobes must not land
    @(negedge i_clk) {i_ce, i_len_wr, i_cnt_wr, i_cfg_value} = {3'b011, 32'h00000055};
    repeat (2) @(negedge i_clk);
    {i_ce, i_len_wr, i_cnt_wr} = 3'b100;
    chk(o_message_length_bytes, 0, "frozen length");
    chk(o_remaining_byte_counter, 0, "frozen counter");
    $display("test enable done");
    // Reset in mid-padding: back to idle, then a clean message
    @(negedge i_clk) {i_len_wr, i_cfg_value} = {1'b1, 32'h00000004};
    @(negedge i_clk) {i_len_wr, i_cnt_wr} = 2'b01;
    @(negedge i_clk) {i_cnt_wr, i_in_valid, i_in_nbytes_m1} = 4'b0111;
    @(negedge i_clk) i_in_valid = 0;
    repeat (2) @(negedge i_clk);
    chk(o_pad_busy, 1, "busy while padding");
    i_rst_b = 0;
    @(negedge i_clk);
    chk({o_in_ready, o_out_valid, o_pad_busy, o_msg_done, o_remaining_byte_counter != 0,
         o_message_length_bytes != 0}, 6'b100000, "mid-run reset state");
    i_rst_b = 1;
    run(4, 4, 4, 0);
    $display("test reset done");
    close_out();
  end
endmodule
